// file: inc/sink_blink_pkg.sv
// constants and types for the sink blink off-time block
package sink_blink_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] ENABLE_ADDR      = 8'h10;
  localparam logic [7:0] ON_TIME_ADDR     = 8'h11;
  localparam logic [7:0] OFF_TIMES_ADDR   = 8'h12;
  localparam logic [7:0] FADE_RATES_ADDR  = 8'h13;
  localparam logic [7:0] ENABLE_RESET     = 8'h00;
  localparam logic [1:0] ON_TIME_RESET    = 2'h0;
  localparam logic [7:0] OFF_TIMES_RESET  = 8'h00;
  localparam logic [7:0] FADE_RATES_RESET = 8'h00;
  localparam int unsigned ON_TIME_LSB     = 6;
  localparam int unsigned OFF_CODE_W      = 2;
  localparam int unsigned SINK_COUNT      = 4;

  // ==========================================================
  // timing: every interval is a whole number of 0.2 s units
  localparam int unsigned UNIT_MS          = 200;
  localparam int unsigned CLK_MHZ          = 250;
  localparam int unsigned UNIT_CYCLES      = UNIT_MS * 1000 * CLK_MHZ;
  localparam logic [3:0]  OFF_UNITS_01     = 4'h3;
  localparam logic [3:0]  OFF_UNITS_10     = 4'h6;
  localparam logic [3:0]  OFF_UNITS_11     = 4'h9;
  localparam logic [3:0]  ON_UNITS_00      = 4'h1;
  localparam logic [3:0]  ON_UNITS_01      = 4'h3;
  localparam logic [3:0]  ON_UNITS_10      = 4'h4;
  localparam logic [3:0]  ON_UNITS_11      = 4'h6;

  // ==========================================================
  // per-sink sequence states, gray along idle-off-on
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_OFF    = 2'b01,
    ST_ON     = 2'b11,
    ST_STEADY = 2'b10
  } sink_state_type;

endpackage

// file: hdl/sink_blink_channel.sv
// blink sequencer for one current sink
`timescale 1ns/1ns
`default_nettype none
module sink_blink_channel (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // shared 0.2 s unit pulse
  input  wire logic       tick,
  // configuration
  input  wire logic       enable,
  input  wire logic [1:0] off_code,
  input  wire logic [1:0] on_code,
  // sink drive
  output var  logic       sink_on
);

  // ==========================================================
  // interval decode
  sink_blink_pkg::sink_state_type state_q;
  sink_blink_pkg::sink_state_type state_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  wire        no_off    = (off_code == 2'b00);
  wire  [3:0] off_units = (off_code == 2'b01) ? sink_blink_pkg::OFF_UNITS_01 :
                          (off_code == 2'b10) ? sink_blink_pkg::OFF_UNITS_10 :
                                                sink_blink_pkg::OFF_UNITS_11;
  wire  [3:0] on_units  = (on_code == 2'b00) ? sink_blink_pkg::ON_UNITS_00 :
                          (on_code == 2'b01) ? sink_blink_pkg::ON_UNITS_01 :
                          (on_code == 2'b10) ? sink_blink_pkg::ON_UNITS_10 :
                                               sink_blink_pkg::ON_UNITS_11;
  wire  [3:0] units     = (state_q == sink_blink_pkg::ST_ON) ? on_units : off_units;
  wire  [3:0] cnt_inc   = cnt_q + 4'h1;
  wire        last_unit = tick && (cnt_inc == units);

  // ==========================================================
  // sequence
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    if (!enable) begin
      state_d = sink_blink_pkg::ST_IDLE;
      cnt_d   = 4'h0;
    end else begin
      case (state_q)
        sink_blink_pkg::ST_IDLE: begin
          // every sink rising in one write leaves idle on the same edge
          state_d = no_off ? sink_blink_pkg::ST_STEADY : sink_blink_pkg::ST_OFF;
          cnt_d   = 4'h0;
        end
        sink_blink_pkg::ST_STEADY: begin
          if (!no_off) begin
            state_d = sink_blink_pkg::ST_OFF;
            cnt_d   = 4'h0;
          end
        end
        sink_blink_pkg::ST_OFF: begin
          if (no_off) begin
            state_d = sink_blink_pkg::ST_STEADY;
            cnt_d   = 4'h0;
          end else if (last_unit) begin
            state_d = sink_blink_pkg::ST_ON;
            cnt_d   = 4'h0;
          end else if (tick) begin
            cnt_d = cnt_inc;
          end
        end
        default: begin
          if (last_unit) begin
            state_d = no_off ? sink_blink_pkg::ST_STEADY : sink_blink_pkg::ST_OFF;
            cnt_d   = 4'h0;
          end else if (tick) begin
            cnt_d = cnt_inc;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= sink_blink_pkg::ST_IDLE;
      cnt_q   <= 4'h0;
      sink_on <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      sink_on <= (state_d == sink_blink_pkg::ST_ON) || (state_d == sink_blink_pkg::ST_STEADY);
    end
  end

  // ==========================================================
  // checks
  chk_disable_off: assert property (@(posedge mclk) disable iff (rst)
    !enable |=> !sink_on && (cnt_q == 4'h0))
    else $error("sink still on or timer not cleared after disable");
  chk_steady_on: assert property (@(posedge mclk) disable iff (rst)
    enable && no_off && $past(enable) |=> sink_on)
    else $error("enabled sink with off code 00 is not on");
  chk_start_off: assert property (@(posedge mclk) disable iff (rst)
    $rose(enable) && !no_off |=> !sink_on ##0 (state_q == sink_blink_pkg::ST_OFF))
    else $error("blink sequence did not start with the off phase");
  chk_off_end: assert property (@(posedge mclk) disable iff (rst)
    enable && !no_off && (state_q == sink_blink_pkg::ST_OFF) && last_unit |=> sink_on)
    else $error("off interval end did not turn the sink on");
  chk_on_end: assert property (@(posedge mclk) disable iff (rst)
    enable && !no_off && (state_q == sink_blink_pkg::ST_ON) && last_unit |=> !sink_on)
    else $error("on interval end did not turn the sink off");

endmodule
`default_nettype wire

// file: hdl/sink_blink_off_timer.sv
// sink blink off-time block: registers, unit divider and four sequencers
`timescale 1ns/1ns
`default_nettype none
module sink_blink_off_timer #(
  parameter int unsigned UNIT_CYCLES = sink_blink_pkg::UNIT_CYCLES
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // register port from the serial interface
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output var  logic [7:0] reg_rdata,
  // sink drive, sink one at bit 0
  output wire logic [3:0] sink_on
);

  localparam int unsigned DIV_W = $clog2(UNIT_CYCLES + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(UNIT_CYCLES - 1);

  // ==========================================================
  // address decode
  wire hit_enable = (reg_addr == sink_blink_pkg::ENABLE_ADDR);
  wire hit_on     = (reg_addr == sink_blink_pkg::ON_TIME_ADDR);
  wire hit_off    = (reg_addr == sink_blink_pkg::OFF_TIMES_ADDR);
  wire hit_fade   = (reg_addr == sink_blink_pkg::FADE_RATES_ADDR);
  // any mapped byte; everything else reads back as zero
  wire hit_any    = hit_enable || hit_on || hit_off || hit_fade;
  wire wr_enable  = reg_wr && hit_enable;
  wire wr_on      = reg_wr && hit_on;
  wire wr_off     = reg_wr && hit_off;
  wire wr_fade    = reg_wr && hit_fade;

  // ==========================================================
  // registers
  logic [3:0]  enable_q;
  logic [1:0]  on_time_q;
  logic [7:0]  off_times_q;
  logic [7:0]  fade_rates_q;
  // whole enable set lands on one edge so a group starts together
  wire  [3:0]  enable_d = wr_enable ? reg_wdata[3:0] : enable_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      enable_q     <= sink_blink_pkg::ENABLE_RESET[3:0];
      on_time_q    <= sink_blink_pkg::ON_TIME_RESET;
      off_times_q  <= sink_blink_pkg::OFF_TIMES_RESET;
      fade_rates_q <= sink_blink_pkg::FADE_RATES_RESET;
    end else begin
      enable_q <= enable_d;
      if (wr_on) begin
        on_time_q <= reg_wdata[sink_blink_pkg::ON_TIME_LSB +: 2];
      end
      if (wr_off) begin
        off_times_q <= reg_wdata;
      end
      if (wr_fade) begin
        fade_rates_q <= reg_wdata;
      end
    end
  end

  // ==========================================================
  // read back; fields of absent sinks read as zero
  wire [7:0] rd_mux = hit_enable ? {4'h0, enable_q} :
                      hit_on     ? {on_time_q, 6'h00} :
                      hit_off    ? off_times_q :
                      hit_fade   ? fade_rates_q :
                                   8'h00;

  always_ff @(posedge mclk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end
  end

  // ==========================================================
  // 0.2 s unit divider, free running
  // limitation: the first unit after an enable can be short by up to one unit
  logic [DIV_W-1:0] div_q;
  logic             tick_q;
  wire              div_end = (div_q == DIV_LAST);

  always_ff @(posedge mclk) begin
    if (rst) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      div_q  <= div_end ? '0 : div_q + DIV_W'(1);
      tick_q <= div_end;
    end
  end

  // ==========================================================
  // per-sink sequencers
  for (genvar i = 0; i < sink_blink_pkg::SINK_COUNT; i++) begin : g_sink
    wire [1:0] off_code = off_times_q[i*sink_blink_pkg::OFF_CODE_W +: 2];
    sink_blink_channel u_channel (
      .mclk     (mclk),
      .rst      (rst),
      .tick     (tick_q),
      .enable   (enable_q[i]),
      .off_code (off_code),
      .on_code  (on_time_q),
      .sink_on  (sink_on[i])
    );
    // a disabled sink must go dark on the next edge whatever its phase
    chk_sink_dark: assert property (@(posedge mclk) disable iff (rst)
      !enable_q[i] |=> !sink_on[i])
      else $error("disabled sink is still on");
    chk_sink_steady: assert property (@(posedge mclk) disable iff (rst)
      $rose(enable_q[i]) && (off_code == 2'b00) |=> sink_on[i])
      else $error("enabled sink with off code 00 did not light");
  end

  // ==========================================================
  // checks
  chk_field_high: assert property (@(posedge mclk) disable iff (rst)
    wr_off |=> (g_sink[3].off_code == $past(reg_wdata[7:6]))
           && (g_sink[2].off_code == $past(reg_wdata[5:4])))
    else $error("sink four or three off code not at bits 7:6 or 5:4");
  chk_field_low: assert property (@(posedge mclk) disable iff (rst)
    wr_off |=> (g_sink[1].off_code == $past(reg_wdata[3:2]))
           && (g_sink[0].off_code == $past(reg_wdata[1:0])))
    else $error("sink two or one off code not at bits 3:2 or 1:0");
  chk_enable_bit0: assert property (@(posedge mclk) disable iff (rst)
    wr_enable && !reg_wdata[0] |=> ##1 !sink_on[0])
    else $error("writing 0 to bit 0 left sink one on");
  chk_on_field: assert property (@(posedge mclk) disable iff (rst)
    wr_on |=> on_time_q == $past(reg_wdata[7:6]))
    else $error("on code not taken from bits 7:6");
  chk_group_start: assert property (@(posedge mclk) disable iff (rst)
    wr_enable && (enable_q[1:0] == 2'b00) && (reg_wdata[1:0] == 2'b11)
      && (off_times_q[1:0] == off_times_q[3:2]) && !wr_off
      |=> ##1 (sink_on[0] == sink_on[1]) [*8])
    else $error("sinks enabled together did not run in step");

  // ==========================================================
  // unit pulse and group checks
  chk_unit_tick: assert property (@(posedge mclk) disable iff (rst)
    tick_q |=> !tick_q)
    else $error("unit pulse longer than one cycle");
  chk_unit_phase: assert property (@(posedge mclk) disable iff (rst)
    tick_q |-> (div_q == '0))
    else $error("unit pulse out of step with the divider");
  // equal codes and a shared unit pulse must keep a group in lock step
  chk_group_upper: assert property (@(posedge mclk) disable iff (rst)
    wr_enable && (enable_q[3:2] == 2'b00) && (reg_wdata[3:2] == 2'b11)
      && (off_times_q[5:4] == off_times_q[7:6]) && !wr_off
      |=> ##1 (sink_on[2] == sink_on[3]) [*8])
    else $error("sinks three and four enabled together did not run in step");

  // ==========================================================
  // register port checks
  // read data are registered, so each byte is checked the edge after its strobe
  chk_enable_write: assert property (@(posedge mclk) disable iff (rst)
    wr_enable |=> enable_q == $past(reg_wdata[3:0]))
    else $error("enable bits not taken from bits 3:0");
  chk_fade_store: assert property (@(posedge mclk) disable iff (rst)
    wr_fade |=> fade_rates_q == $past(reg_wdata))
    else $error("fade rate byte not stored");
  chk_enable_read: assert property (@(posedge mclk) disable iff (rst)
    reg_rd && hit_enable |=> reg_rdata == {4'h0, $past(enable_q)})
    else $error("enable bits read back wrong");
  chk_on_read: assert property (@(posedge mclk) disable iff (rst)
    reg_rd && hit_on |=> reg_rdata == {$past(on_time_q), 6'h00})
    else $error("on code read back wrong");
  chk_off_read: assert property (@(posedge mclk) disable iff (rst)
    reg_rd && hit_off |=> reg_rdata == $past(off_times_q))
    else $error("off codes read back wrong");
  chk_unmapped_zero: assert property (@(posedge mclk) disable iff (rst)
    reg_rd && !hit_any |=> reg_rdata == 8'h00)
    else $error("unmapped read did not return zero");
  chk_rdata_hold: assert property (@(posedge mclk) disable iff (rst)
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");

  // ==========================================================
  // registers move only on their own write strobe
  chk_enable_hold: assert property (@(posedge mclk) disable iff (rst)
    !wr_enable |=> $stable(enable_q))
    else $error("enable bits changed without a write");
  chk_on_hold: assert property (@(posedge mclk) disable iff (rst)
    !wr_on |=> $stable(on_time_q))
    else $error("on code changed without a write");
  chk_off_hold: assert property (@(posedge mclk) disable iff (rst)
    !wr_off |=> $stable(off_times_q))
    else $error("off codes changed without a write");
  chk_fade_hold: assert property (@(posedge mclk) disable iff (rst)
    !wr_fade |=> $stable(fade_rates_q))
    else $error("fade rate byte changed without a write");

  // ==========================================================
  // reset leaves every register and output cleared
  // no disable here: the check looks at the first edge out of reset
  chk_reset_clear: assert property (@(posedge mclk)
    $fell(rst) |-> (enable_q == sink_blink_pkg::ENABLE_RESET[3:0])
      && (on_time_q == sink_blink_pkg::ON_TIME_RESET)
      && (off_times_q == sink_blink_pkg::OFF_TIMES_RESET)
      && (fade_rates_q == sink_blink_pkg::FADE_RATES_RESET)
      && (reg_rdata == 8'h00) && (sink_on == 4'h0))
    else $error("register or output not cleared by reset");

  // ==========================================================
  // coverage
  cov_blink_sink1: cover property (@(posedge mclk) disable iff (rst)
    enable_q[0] && $rose(sink_on[0]) ##[1:1000] $fell(sink_on[0]));
  cov_steady_sink4: cover property (@(posedge mclk) disable iff (rst)
    enable_q[3] && (off_times_q[7:6] == 2'b00) && sink_on[3]);
  cov_group_write: cover property (@(posedge mclk) disable iff (rst)
    wr_enable && (reg_wdata[3:0] == 4'hf) && (enable_q == 4'h0));
  cov_disable_mid: cover property (@(posedge mclk) disable iff (rst)
    wr_enable && sink_on[2] && !reg_wdata[2]);
  cov_steady_switch: cover property (@(posedge mclk) disable iff (rst)
    enable_q[0] && !sink_on[0] && wr_off && (reg_wdata[1:0] == 2'b00));

endmodule
`default_nettype wire

// file: testbench/led_load.sv
// behavioural led loads that tally how long each sink stays lit
`timescale 1ns/1ns
`default_nettype none
module led_load (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // sink drive, sink one at bit 0
  input  wire logic [3:0]       sink_on,
  // lit cycles per sink
  output var  logic [3:0][15:0] lit_cnt
);
  // ==========================================================
  // lit-time tally
  // a lit load only draws current, so the tally is all it can report
  always_ff @(posedge mclk) begin
    for (int i = 0; i < 4; i++) begin
      if (rst) begin
        lit_cnt[i] <= 16'h0000;
      end else if (sink_on[i]) begin
        lit_cnt[i] <= lit_cnt[i] + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// file: testbench/sink_blink_off_timer_tb.sv
// self-checking bench for the sink blink off-time block
`timescale 1ns/1ns
`default_nettype none
module sink_blink_off_timer_tb;
  localparam int unsigned UNIT = 4;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_type;
  logic             mclk      = 1'b0;
  logic             rst       = 1'b1;
  logic             reg_wr    = 1'b0;
  logic             reg_rd    = 1'b0;
  logic [7:0]       reg_addr  = 8'h00;
  logic [7:0]       reg_wdata = 8'h00;
  logic [7:0]       reg_rdata;
  logic [7:0]       got;
  wire  logic [3:0] sink_on;
  logic [3:0][15:0] lit_cnt;
  int               fail_count = 0;
  int               compares   = 0;
  // unmapped 0x20 must read zero
  row_type rows [5] = '{'{8'h10, 8'hFF, 8'h0F}, '{8'h11, 8'hFF, 8'hC0},
    '{8'h12, 8'hA5, 8'hA5}, '{8'h13, 8'h3C, 8'h3C}, '{8'h20, 8'hFF, 8'h00}};
  // ==========================================================
  // design and loads
  sink_blink_off_timer #(.UNIT_CYCLES(UNIT)) DUT (.mclk(mclk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sink_on(sink_on));
  led_load loads (.mclk(mclk), .rst(rst), .sink_on(sink_on), .lit_cnt(lit_cnt));
  initial begin
    forever #2 mclk = ~mclk;
  end
  // ==========================================================
  // shared tasks
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic pulse_reset();
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
  endtask
  // run lengths are exact once the first, quantized unit is behind us
  task automatic blink(input logic [1:0] off, input logic [1:0] on, input int ou, input int nu);
    int n;
    int hi;
    int lo;
    wr(8'h11, {on, 6'h00});
    wr(8'h12, {6'h00, off});
    wr(8'h10, 8'h01);
    n = 0;
    while (sink_on[0] !== 1'b1 && n < 100) begin @(posedge mclk); #1 n++; end
    hi = 0;
    while (sink_on[0] === 1'b1 && hi < 100) begin hi++; @(posedge mclk); #1; end
    lo = 0;
    while (sink_on[0] === 1'b0 && lo < 100) begin lo++; @(posedge mclk); #1; end
    chk(16'(hi), 16'(nu * UNIT));
    chk(16'(lo), 16'(ou * UNIT));
    wr(8'h10, 8'h00);
    repeat (2) @(posedge mclk);
    #1 chk(16'(sink_on), 16'h0000);
  endtask
  task automatic close_out();
    $display("compares %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ==========================================================
  // tests
  initial begin
    #200000;
    fail_count++;
    close_out();
  end
  initial begin
    logic [1:0] offs [4] = '{2'h1, 2'h1, 2'h2, 2'h3};
    int         ou   [4] = '{3, 3, 6, 9};
    int         nu   [4] = '{1, 3, 4, 6};
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, got);
      chk(16'(got), 16'(rows[i].e));
    end
    $display("test register rows done");
    pulse_reset();
    for (int a = 16; a < 20; a++) begin
      rd(8'(a), got);
      chk(16'(got), 16'h0000);
    end
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      blink(offs[i], 2'(i), ou[i], nu[i]);
    end
    $display("test blink timing done");
    wr(8'h12, 8'h03);
    wr(8'h10, 8'h05);
    repeat (4) @(posedge mclk);
    #1 chk(16'(sink_on), 16'h0004);
    wr(8'h12, 8'h00);
    repeat (2) @(posedge mclk);
    repeat (30) begin @(posedge mclk); #1 chk(16'(sink_on), 16'h0005); end
    wr(8'h10, 8'h00);
    repeat (2) @(posedge mclk);
    #1 chk(16'(sink_on), 16'h0000);
    $display("test steady sink done");
    pulse_reset();
    wr(8'h11, 8'h40);
    wr(8'h12, 8'h55);
    wr(8'h10, 8'h0F);
    repeat (80) begin @(posedge mclk); #1 chk(16'(sink_on), {12'h000, {4{sink_on[0]}}}); end
    chk(lit_cnt[3], lit_cnt[0]);
    chk(16'(lit_cnt[1] != 16'h0000), 16'h0001);
    $display("test grouped start done");
    close_out();
  end
endmodule
`default_nettype wire
